// *** design/tsg_pkg.sv ***
/*
 * Shared constants and types of the trace timestamp and synchronization generator.
 * Assumes a single 40 MHz clock and an AXI4-Lite register bus with 32-bit data.
 */
package tsg_pkg;

    localparam int LTS_W = 28;
    localparam int GTS_W = 64;
    localparam int GTS_LO_W = 26;
    localparam int GTS_HI_W = GTS_W - GTS_LO_W;
    localparam int ADDR_W = 8;

    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;

    localparam int CTRL_LTS_EN = 0;
    localparam int CTRL_CLK_SEL = 1;
    localparam int CTRL_PRESC = 2;
    localparam int CTRL_FREQ = 4;
    localparam int CTRL_SYNC_EN = 6;
    localparam int STAT_BUSY = 31;
    localparam logic [6:0] CTRL_RESET = 7'h00;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam logic [7:0] HDR_OVERFLOW = 8'h70;
    localparam logic [7:0] HDR_LTS = 8'h40;
    localparam logic [7:0] HDR_GTS1 = 8'h94;
    localparam logic [7:0] HDR_GTS2 = 8'hb4;
    localparam logic [7:0] SYNC_LAST = 8'h80;
    localparam logic [2:0] LEN_SYNC = 3'h6;
    localparam logic [2:0] LEN_GTS1 = 3'h5;
    localparam logic [2:0] LEN_GTS2 = 3'h7;
    localparam logic [LTS_W-1:0] LTS_NEAR_FULL = 28'hff00000;

    typedef struct packed {
        logic [ADDR_W-1:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [ADDR_W-1:0] araddr;
        logic arvalid;
        logic rready;
    } tsg_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } tsg_axi_rsp_t;

    typedef struct packed {
        logic sync_packet_enable;
        logic [1:0] global_ts_frequency;
        logic [1:0] ts_prescale_divide;
        logic ts_clock_select;
        logic local_ts_enable;
    } tsg_ctrl_t;

    typedef struct packed {
        logic [7:0] data;
        logic last;
        logic valid;
    } tsg_byte_t;

    typedef enum logic [1:0] {
        TSG_IDLE = 2'b01,
        TSG_SEND = 2'b10
    } tsg_state_t;

endpackage

// *** design/tsg_prescaler.sv ***
/*
 * Port clock prescaler: brings the trace port clock into the processor clock
 * domain and emits one tick per divided port clock edge.
 * Assumes the port clock is well below half the processor clock rate.
 */
`timescale 1ns/1ps
`default_nettype none
module tsg_prescaler (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic port_clk_i,
    input wire logic [1:0] divide_i,
    input wire logic clear_i,
    output logic tick_o
);
    typedef struct packed {
        logic sync0;
        logic sync1;
        logic prev;
        logic [5:0] div_cnt;
        logic tick;
    } tsg_presc_state_t;

    tsg_presc_state_t st_reg;
    tsg_presc_state_t st_next;
    logic [5:0] div_top;
    logic rise;

    always_comb begin
        unique case (divide_i)
            2'h0: div_top = 6'd0;
            2'h1: div_top = 6'd3;
            2'h2: div_top = 6'd15;
            2'h3: div_top = 6'd63;
        endcase
    end

    // The first stage feeds only the second; edges are taken after it.
    assign rise = st_reg.sync1 & ~st_reg.prev;

    always_comb begin
        st_next = st_reg;
        st_next.sync0 = port_clk_i;
        st_next.sync1 = st_reg.sync0;
        st_next.prev = st_reg.sync1;
        st_next.tick = 1'b0;
        if (clear_i) begin
            st_next.div_cnt = 6'd0;
        end else if (rise) begin
            if (st_reg.div_cnt >= div_top) begin
                st_next.div_cnt = 6'd0;
                st_next.tick = 1'b1;
            end else begin
                st_next.div_cnt = st_reg.div_cnt + 6'd1;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign tick_o = st_reg.tick;
endmodule
`default_nettype wire

// *** design/tsg_generator.sv ***
/*
 * Timestamp and synchronization packet generator with an AXI4-Lite register slave.
 * Assumes the trace port unit takes bytes with a valid/ready handshake and the
 * event, request and global time inputs are synchronous to mclk_i.
 */
// Implementation choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module tsg_generator #(
    parameter bit CYCLE_COUNTER_PRESENT = 1'b1,
    parameter bit PORT_SYNC_PRESENT = 1'b1
) (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire tsg_pkg::tsg_axi_req_t axi_req_i,
    output tsg_pkg::tsg_axi_rsp_t axi_rsp_o,
    input wire logic event_push_i,
    input wire logic event_delayed_i,
    input wire logic debug_state_i,
    input wire logic port_clk_i,
    input wire logic port_idle_i,
    input wire logic [tsg_pkg::GTS_W-1:0] global_time_i,
    input wire logic clock_ratio_change_i,
    input wire logic [1:0] sync_tap_select_i,
    input wire logic sync_req_watch_i,
    input wire logic sync_req_port_i,
    input wire logic sync_req_system_i,
    input wire logic tx_ready_i,
    output tsg_pkg::tsg_byte_t tx_o
);
    typedef struct packed {
        tsg_pkg::tsg_axi_rsp_t rsp;
        logic aw_got;
        logic w_got;
        logic [tsg_pkg::ADDR_W-1:0] aw_addr;
        logic [7:0] w_byte;
        logic w_strb0;
        tsg_pkg::tsg_ctrl_t ctrl;
        logic [tsg_pkg::LTS_W-1:0] cnt;
        logic wrapped;
        logic lts_pend;
        logic lts_ts_dly;
        logic lts_ev_dly;
        logic ovf_pend;
        logic sync_pend;
        logic gts1_pend;
        logic gts_full;
        logic gts_clkch;
        logic gts2_pend;
        logic [tsg_pkg::GTS_HI_W-1:0] hi_sent;
        logic [tsg_pkg::GTS_HI_W-1:0] hi_pkt;
        logic [1:0] freq_prev;
        logic sync_en_prev;
        logic dbg_prev;
        tsg_pkg::tsg_state_t state;
        logic [6:0][7:0] sh;
        logic [2:0] left;
        tsg_pkg::tsg_byte_t tx;
    } tsg_gen_state_t;

    tsg_gen_state_t st_reg;
    tsg_gen_state_t st_next;
    logic presc_tick;

    // Number of 7-bit groups needed to hold a count, at least one.
    function automatic logic [2:0] tsg_groups(input logic [tsg_pkg::LTS_W-1:0] v);
        logic [2:0] n;
        n = 3'd1;
        if (v[27:21] != 7'd0) begin
            n = 3'd4;
        end else if (v[20:14] != 7'd0) begin
            n = 3'd3;
        end else if (v[13:7] != 7'd0) begin
            n = 3'd2;
        end
        return n;
    endfunction

    function automatic logic [31:0] tsg_read(input tsg_gen_state_t s);
        logic [31:0] d;
        d = 32'h0;
        d[6:0] = s.ctrl;
        return d;
    endfunction

    tsg_prescaler u_presc (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .port_clk_i(port_clk_i),
        .divide_i(st_reg.ctrl.ts_prescale_divide),
        .clear_i(port_idle_i),
        .tick_o(presc_tick)
    );

    always_comb begin
        logic run;
        logic tick;
        logic busy;
        logic sync_raw;
        logic sync_req;
        logic gts_on;
        logic full_req;
        logic load;
        logic [6:0][7:0] pkt;
        logic [6:0][6:0] pay;
        logic [2:0] plen;
        logic cont;
        logic [tsg_pkg::LTS_W-1:0] val;
        logic [tsg_pkg::GTS_HI_W-1:0] hi;
        logic full;
        logic [2:0] n;
        run = 1'b0;
        tick = 1'b0;
        busy = 1'b0;
        sync_raw = 1'b0;
        sync_req = 1'b0;
        gts_on = 1'b0;
        full_req = 1'b0;
        load = 1'b0;
        pkt = '0;
        pay = '0;
        plen = 3'd1;
        cont = 1'b1;
        val = '0;
        hi = '0;
        full = 1'b0;
        n = 3'd1;
        st_next = st_reg;

        // Register slave: address and data are taken in either order.
        if (axi_req_i.awvalid && st_reg.rsp.awready) begin
            st_next.aw_got = 1'b1;
            st_next.aw_addr = axi_req_i.awaddr;
        end
        if (axi_req_i.wvalid && st_reg.rsp.wready) begin
            st_next.w_got = 1'b1;
            st_next.w_byte = axi_req_i.wdata[7:0];
            st_next.w_strb0 = axi_req_i.wstrb[0];
        end
        if (st_reg.rsp.bvalid && axi_req_i.bready) begin
            st_next.rsp.bvalid = 1'b0;
        end
        if (st_reg.aw_got && st_reg.w_got && !st_reg.rsp.bvalid) begin
            st_next.aw_got = 1'b0;
            st_next.w_got = 1'b0;
            st_next.rsp.bvalid = 1'b1;
            st_next.rsp.bresp = tsg_pkg::RESP_OKAY;
            if (st_reg.aw_addr[7:2] == tsg_pkg::OFS_CTRL[7:2]) begin
                if (st_reg.w_strb0) begin
                    st_next.ctrl = st_reg.w_byte[6:0];
                end
            end else if (st_reg.aw_addr[7:2] != tsg_pkg::OFS_STATUS[7:2]) begin
                st_next.rsp.bresp = tsg_pkg::RESP_SLVERR;
            end
        end
        st_next.rsp.awready = !st_next.aw_got;
        st_next.rsp.wready = !st_next.w_got;

        if (st_reg.rsp.rvalid && axi_req_i.rready) begin
            st_next.rsp.rvalid = 1'b0;
            st_next.rsp.arready = 1'b1;
        end
        if (axi_req_i.arvalid && st_reg.rsp.arready) begin
            st_next.rsp.arready = 1'b0;
            st_next.rsp.rvalid = 1'b1;
            st_next.rsp.rresp = tsg_pkg::RESP_OKAY;
            if (axi_req_i.araddr[7:2] == tsg_pkg::OFS_CTRL[7:2]) begin
                st_next.rsp.rdata = tsg_read(st_reg);
            end else if (axi_req_i.araddr[7:2] == tsg_pkg::OFS_STATUS[7:2]) begin
                st_next.rsp.rdata = {4'h0, st_reg.cnt};
                st_next.rsp.rdata[tsg_pkg::STAT_BUSY] = st_reg.state != tsg_pkg::TSG_IDLE;
            end else begin
                st_next.rsp.rdata = 32'h0;
                st_next.rsp.rresp = tsg_pkg::RESP_SLVERR;
            end
        end

        // Local delta counter.
        busy = (st_reg.state != tsg_pkg::TSG_IDLE) || st_reg.sync_pend || st_reg.ovf_pend;
        if (st_reg.ctrl.ts_clock_select) begin
            run = st_reg.ctrl.local_ts_enable;
            tick = presc_tick;
        end else begin
            run = st_reg.ctrl.local_ts_enable && !debug_state_i;
            tick = 1'b1;
        end
        if (st_reg.ctrl.ts_clock_select && port_idle_i) begin
            st_next.cnt = '0;
            st_next.wrapped = 1'b0;
        end else if (run && tick) begin
            st_next.cnt = st_reg.cnt + 28'd1;
            if (&st_reg.cnt) begin
                st_next.wrapped = 1'b1;
                st_next.ovf_pend = 1'b1;
            end
        end
        if (st_reg.ctrl.local_ts_enable && !st_reg.lts_pend) begin
            if (event_push_i && (st_reg.cnt != '0 || st_reg.wrapped)) begin
                st_next.lts_pend = 1'b1;
                st_next.lts_ev_dly = event_delayed_i;
                st_next.lts_ts_dly = busy;
            end else if (st_reg.cnt >= tsg_pkg::LTS_NEAR_FULL || st_reg.wrapped) begin
                st_next.lts_pend = 1'b1;
                st_next.lts_ev_dly = 1'b0;
                st_next.lts_ts_dly = st_reg.wrapped;
            end
        end

        // Global time triggers.
        gts_on = st_reg.ctrl.global_ts_frequency != 2'h0;
        sync_raw = (sync_req_watch_i && CYCLE_COUNTER_PRESENT && sync_tap_select_i != 2'h0)
            || (sync_req_port_i && PORT_SYNC_PRESENT) || sync_req_system_i;
        full_req = (st_reg.freq_prev == 2'h0 && gts_on) || clock_ratio_change_i
            || (gts_on && sync_raw);
        if (full_req || (gts_on && event_push_i)) begin
            st_next.gts1_pend = 1'b1;
        end
        if (full_req) begin
            st_next.gts_full = 1'b1;
        end
        if (clock_ratio_change_i) begin
            st_next.gts_clkch = 1'b1;
        end
        st_next.freq_prev = st_reg.ctrl.global_ts_frequency;

        // Synchronization triggers.
        sync_req = sync_raw || (st_reg.ctrl.sync_packet_enable && !st_reg.sync_en_prev)
            || (st_reg.dbg_prev && !debug_state_i);
        if (st_reg.ctrl.sync_packet_enable && sync_req) begin
            st_next.sync_pend = 1'b1;
        end
        st_next.sync_en_prev = st_reg.ctrl.sync_packet_enable;
        st_next.dbg_prev = debug_state_i;

        // Output serializer.
        if (st_reg.state == tsg_pkg::TSG_SEND) begin
            if (tx_ready_i) begin
                st_next.sh = {8'h00, st_reg.sh[6:1]};
                st_next.left = st_reg.left - 3'd1;
                st_next.tx.data = st_reg.sh[1];
                st_next.tx.last = st_reg.left == 3'd2;
                if (st_reg.left == 3'd1) begin
                    st_next.state = tsg_pkg::TSG_IDLE;
                    st_next.tx = '0;
                end
            end
        end else if (st_reg.sync_pend) begin
            load = 1'b1;
            st_next.sync_pend = sync_req && st_reg.ctrl.sync_packet_enable;
            pkt[5] = tsg_pkg::SYNC_LAST;
            plen = tsg_pkg::LEN_SYNC;
            cont = 1'b0;
        end else if (st_reg.ovf_pend) begin
            load = 1'b1;
            st_next.ovf_pend = 1'b0;
            pkt[0] = tsg_pkg::HDR_OVERFLOW;
        end else if (st_reg.lts_pend) begin
            load = 1'b1;
            st_next.lts_pend = 1'b0;
            st_next.cnt = '0;
            st_next.wrapped = 1'b0;
            val = st_reg.cnt;
            n = tsg_groups(val);
            pkt[0] = tsg_pkg::HDR_LTS | {2'b00, st_reg.lts_ev_dly, st_reg.lts_ts_dly, 4'h0};
            for (int i = 0; i < 4; i++) begin
                pay[i+1] = val[7*i +: 7];
            end
            plen = n + 3'd1;
        end else if (st_reg.gts1_pend) begin
            load = 1'b1;
            hi = global_time_i[tsg_pkg::GTS_W-1:tsg_pkg::GTS_LO_W];
            full = st_reg.gts_full || st_reg.gts2_pend || hi != st_reg.hi_sent;
            st_next.gts1_pend = full_req || (gts_on && event_push_i);
            st_next.gts_full = full_req;
            st_next.gts_clkch = clock_ratio_change_i;
            pkt[0] = tsg_pkg::HDR_GTS1;
            pay[1] = global_time_i[6:0];
            pay[2] = global_time_i[13:7];
            pay[3] = global_time_i[20:14];
            pay[4] = {full && (!st_reg.gts_clkch || st_reg.gts2_pend),
                      full && st_reg.gts_clkch, global_time_i[25:21]};
            plen = tsg_pkg::LEN_GTS1;
            if (full) begin
                st_next.gts2_pend = 1'b1;
                st_next.hi_pkt = hi;
            end
        end else if (st_reg.gts2_pend) begin
            load = 1'b1;
            st_next.gts2_pend = 1'b0;
            st_next.hi_sent = st_reg.hi_pkt;
            pkt[0] = tsg_pkg::HDR_GTS2;
            for (int i = 0; i < 6; i++) begin
                pay[i+1] = 7'(st_reg.hi_pkt >> (7*i));
            end
            plen = tsg_pkg::LEN_GTS2;
        end
        if (load) begin
            for (int i = 1; i < 7; i++) begin
                if (cont) begin
                    pkt[i] = {1'b0, pay[i]};
                end
            end
            for (int i = 0; i < 7; i++) begin
                if (cont && (3'(i) < plen - 3'd1)) begin
                    pkt[i][7] = 1'b1;
                end
            end
            st_next.sh = pkt;
            st_next.left = plen;
            st_next.state = tsg_pkg::TSG_SEND;
            st_next.tx.valid = 1'b1;
            st_next.tx.data = pkt[0];
            st_next.tx.last = plen == 3'd1;
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_reg <= '0;
            st_reg.rsp.awready <= 1'b1;
            st_reg.rsp.wready <= 1'b1;
            st_reg.rsp.arready <= 1'b1;
            st_reg.ctrl <= tsg_pkg::CTRL_RESET;
            st_reg.state <= tsg_pkg::TSG_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    assign axi_rsp_o = st_reg.rsp;
    assign tx_o = st_reg.tx;
endmodule
`default_nettype wire

// *** testbench/tsg_props.sv ***
/*
 * Port checker for the timestamp and sync generator: byte stream and register bus.
 * Assumes it is bound to tsg_generator and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none
module tsg_props (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire tsg_pkg::tsg_axi_req_t axi_req_i,
    input wire tsg_pkg::tsg_axi_rsp_t axi_rsp_o,
    input wire logic tx_ready_i,
    input wire tsg_pkg::tsg_byte_t tx_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!nrst_i);
    sequence s_stall;
        tx_o.valid && !tx_ready_i;
    endsequence
    sequence s_wr_taken;
        axi_req_i.awvalid && axi_rsp_o.awready && axi_req_i.wvalid && axi_rsp_o.wready;
    endsequence
    sequence s_rd_taken;
        axi_req_i.arvalid && axi_rsp_o.arready;
    endsequence
    a_byte_hold: assert property (s_stall |=> tx_o.valid && $stable(tx_o.data) && $stable(tx_o.last))
        else $error("stalled byte changed");
    a_cont_set: assert property (tx_o.valid && !tx_o.last && tx_o.data != 8'h00 |-> tx_o.data[7])
        else $error("continuation bit missing");
    a_last_clear: assert property (tx_o.valid && tx_o.last |-> !tx_o.data[7] || tx_o.data == tsg_pkg::SYNC_LAST)
        else $error("final byte has bit 7 set");
    a_write_resp: assert property (s_wr_taken |-> ##[1:2] axi_rsp_o.bvalid)
        else $error("write response late");
    a_write_block: assert property (s_wr_taken |=> !axi_rsp_o.awready && !axi_rsp_o.wready)
        else $error("write ready not dropped");
    a_read_resp: assert property (s_rd_taken |=> axi_rsp_o.rvalid && !axi_rsp_o.arready)
        else $error("read response late");
    a_bresp_hold: assert property (axi_rsp_o.bvalid && !axi_req_i.bready |=> axi_rsp_o.bvalid && $stable(axi_rsp_o.bresp))
        else $error("write response dropped");
    a_rdata_hold: assert property (axi_rsp_o.rvalid && !axi_req_i.rready |=> axi_rsp_o.rvalid && $stable(axi_rsp_o.rdata))
        else $error("read data dropped");
    a_unmapped_err: assert property (axi_req_i.arvalid && axi_rsp_o.arready
        && axi_req_i.araddr[7:2] != tsg_pkg::OFS_CTRL[7:2]
        && axi_req_i.araddr[7:2] != tsg_pkg::OFS_STATUS[7:2]
        |=> axi_rsp_o.rresp == tsg_pkg::RESP_SLVERR && axi_rsp_o.rdata == 32'h0)
        else $error("unmapped read not refused");
endmodule
bind tsg_generator tsg_props u_props (.mclk_i(mclk_i), .nrst_i(nrst_i), .axi_req_i(axi_req_i),
    .axi_rsp_o(axi_rsp_o), .tx_ready_i(tx_ready_i), .tx_o(tx_o));
`default_nettype wire

// *** testbench/tsg_trace_sink.sv ***
/*
 * Trace port model: takes bytes from the generator and queues them with their last flag.
 * Assumes stall_i asks for random back-pressure.
 */
`timescale 1ns/1ps
`default_nettype none
module tsg_trace_sink (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire tsg_pkg::tsg_byte_t tx_i,
    input wire logic stall_i,
    output logic tx_ready_o
);
    logic [8:0] got[$];
    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tx_ready_o <= 1'b0;
        end else begin
            if (tx_i.valid && tx_ready_o)
                got.push_back({tx_i.last, tx_i.data});
            tx_ready_o <= !stall_i || ($urandom_range(0, 2) == 0);
        end
    end
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
/*
 * Self-checking bench for the timestamp and sync generator.
 * Assumes the trace sink model and the bound port checker.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    tsg_pkg::tsg_axi_req_t req = '0;
    tsg_pkg::tsg_axi_rsp_t rsp;
    tsg_pkg::tsg_byte_t tx;
    logic ev = 0, evd = 0, dbg = 0, pclk = 0, pidle = 0, ratio = 0;
    logic swatch = 0, sport = 0, ssys = 0, stall = 0, ready;
    logic [1:0] tap = 2'h0;
    logic [1:0] fl;
    logic [63:0] gtime = 64'h0;
    logic [2:0] pdiv = 3'h0;
    logic [31:0] d, c, c1, c2;
    logic [1:0] r;
    logic [8:0] pkt[$];
    int err_total = 0, checks_done = 0, g1, g2;
    always #12.5 mclk = ~mclk;
    always @(posedge mclk) begin
        pdiv <= (pdiv == 3'h2) ? 3'h0 : pdiv + 3'h1;
        if (pdiv == 3'h2)
            pclk <= ~pclk;
    end
    tsg_generator DUT (.mclk_i(mclk), .nrst_i(nrst), .axi_req_i(req), .axi_rsp_o(rsp),
        .event_push_i(ev), .event_delayed_i(evd), .debug_state_i(dbg), .port_clk_i(pclk),
        .port_idle_i(pidle), .global_time_i(gtime), .clock_ratio_change_i(ratio),
        .sync_tap_select_i(tap), .sync_req_watch_i(swatch), .sync_req_port_i(sport),
        .sync_req_system_i(ssys), .tx_ready_i(ready), .tx_o(tx));
    tsg_trace_sink sink (.mclk_i(mclk), .nrst_i(nrst), .tx_i(tx), .stall_i(stall), .tx_ready_o(ready));
    task tick(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task tally_and_finish;
        if (err_total == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task axi_wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
        req.awaddr <= a;
        req.wdata <= v;
        req.wstrb <= s;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        for (int n = 0; n < 100; n++) begin
            @(posedge mclk);
            if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
            if (rsp.bvalid === 1'b1) begin
                r = rsp.bresp;
                break;
            end
        end
        req.bready <= 1'b0;
        tick(1);
    endtask
    task axi_rd(input logic [7:0] a);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        for (int n = 0; n < 100; n++) begin
            @(posedge mclk);
            if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
            if (rsp.rvalid === 1'b1) begin
                d = rsp.rdata;
                r = rsp.rresp;
                break;
            end
        end
        req.rready <= 1'b0;
        tick(1);
    endtask
    // Pulses one request line for a cycle: 4 watch, 3 port, 2 system, 1 ratio, 0 event.
    task trig(input int k, input logic dl);
        {swatch, sport, ssys, ratio, ev} <= 5'(1 << k);
        evd <= dl;
        @(posedge mclk);
        {swatch, sport, ssys, ratio, ev} <= 5'h0;
        evd <= 1'b0;
    endtask
    task get_pkt;
        pkt = {};
        for (int n = 0; n < 3000; n++) begin
            while (sink.got.size() > 0) begin
                pkt.push_back(sink.got.pop_front());
                if (pkt[$][8]) return;
            end
            @(posedge mclk);
        end
        err_total++;
    endtask
    task none_check;
        tick(80);
        chk(32'(sink.got.size()), 32'h0);
    endtask
    task sync_check;
        get_pkt();
        chk(32'(pkt.size()), 32'h6);
        for (int i = 0; i < 6; i++)
            chk(32'(pkt[i]), (i == 5) ? {1'b1, tsg_pkg::SYNC_LAST} : 32'h0);
    endtask
    function logic [8:0] gexp(input logic [63:0] v, input int i, input int n, input logic [6:0] m);
        return {i == n, i < n, 7'(v >> (7 * (i - 1))) & m};
    endfunction
    task gts_one(input logic [63:0] v, input logic [7:0] hdr, input int n, input int bits);
        logic [6:0] m;
        get_pkt();
        chk(32'(pkt.size()), 32'(n + 1));
        chk(32'(pkt[0]), {24'h0, hdr});
        for (int i = 1; i <= n; i++) begin
            m = (i == n) ? 7'((1 << (bits - 7 * (n - 1))) - 1) : 7'h7f;
            chk({pkt[i][8:7], pkt[i][6:0] & m}, gexp(v, i, n, m));
        end
    endtask
    task gts_pair;
        gts_one({38'h0, gtime[25:0]}, tsg_pkg::HDR_GTS1, 4, 26);
        fl = pkt[4][6:5];
        gts_one(gtime >> 26, tsg_pkg::HDR_GTS2, 6, 38);
    endtask
    task lts_check(input logic dl, output logic [31:0] cnt);
        get_pkt();
        cnt = 32'h0;
        for (int i = 1; i < pkt.size(); i++)
            cnt = cnt | (32'(pkt[i][6:0]) << (7 * (i - 1)));
        chk({pkt[0][8:5], pkt[0][3:0]}, {3'b011, dl, 4'h0});
        chk(32'(pkt[$][6:0] != 7'h0), 32'h1);
    endtask
    initial begin
        tick(30000);
        err_total++;
        tally_and_finish();
    end
    initial begin
        g1 = $urandom(17875);
        tick(16);
        nrst <= 1'b1;
        tick(2);
        axi_rd(tsg_pkg::OFS_CTRL);
        chk(d, 32'h0);
        axi_wr(tsg_pkg::OFS_CTRL, 32'h0000000c, 4'hf);
        chk({30'h0, r}, 32'(tsg_pkg::RESP_OKAY));
        axi_wr(tsg_pkg::OFS_CTRL, 32'h00000001, 4'h0);
        axi_rd(tsg_pkg::OFS_CTRL);
        chk(d, 32'h0000000c);
        axi_rd(8'h08);
        chk({30'h0, r}, 32'(tsg_pkg::RESP_SLVERR));
        axi_wr(8'h08, 32'h0, 4'hf);
        chk({30'h0, r}, 32'(tsg_pkg::RESP_SLVERR));
        axi_rd(tsg_pkg::OFS_STATUS);
        chk(d, 32'h0);
        stall <= 1'b1;
        axi_wr(tsg_pkg::OFS_CTRL, 32'h00000040, 4'hf);
        sync_check();
        tap <= 2'($urandom_range(1, 3));
        for (int j = 0; j < 4; j++) begin
            if (j < 3) begin
                trig(4 - j, 1'b0);
            end else begin
                dbg <= 1'b1;
                tick(20);
                dbg <= 1'b0;
            end
            sync_check();
        end
        tap <= 2'h0;
        trig(4, 1'b0);
        none_check();
        gtime <= {$urandom, $urandom};
        axi_wr(tsg_pkg::OFS_CTRL, 32'h00000010, 4'hf);
        gts_pair();
        chk(32'(fl != 2'h0), 32'h1);
        trig(1, 1'b0);
        gts_pair();
        chk(32'(fl[0]), 32'h1);
        trig(2, 1'b0);
        gts_pair();
        stall <= 1'b0;
        axi_wr(tsg_pkg::OFS_CTRL, 32'h00000000, 4'hf);
        trig(0, 1'b0);
        none_check();
        axi_wr(tsg_pkg::OFS_CTRL, 32'h00000001, 4'hf);
        g1 = 127;
        g2 = 200 + $urandom_range(0, 3000);
        tick(30);
        trig(0, 1'b0);
        tick(g1 - 1);
        trig(0, 1'b0);
        tick(g2 - 1);
        trig(0, 1'b1);
        lts_check(1'b0, c);
        lts_check(1'b0, c1);
        lts_check(1'b1, c2);
        chk(32'(c1 + 1 >= g1 && c1 <= g1 + 1), 32'h1);
        chk(c2 - c1, 32'(g2 - g1));
        trig(0, 1'b0);
        dbg <= 1'b1;
        tick(100);
        dbg <= 1'b0;
        tick(19);
        trig(0, 1'b0);
        lts_check(1'b0, c);
        lts_check(1'b0, c);
        chk(32'(c < 60), 32'h1);
        pidle <= 1'b1;
        // Port clock mode is chosen while the port is idle, which holds the counter clear.
        axi_wr(tsg_pkg::OFS_CTRL, 32'h00000003, 4'hf);
        tick(50);
        trig(0, 1'b0);
        none_check();
        pidle <= 1'b0;
        tick(200);
        trig(0, 1'b0);
        lts_check(1'b0, c);
        chk(32'(c != 0 && c <= 80), 32'h1);
        axi_wr(tsg_pkg::OFS_CTRL, 32'h00000007, 4'hf);
        tick(60);
        trig(0, 1'b0);
        tick(240);
        trig(0, 1'b0);
        lts_check(1'b0, c);
        lts_check(1'b0, c);
        chk(32'(c != 0 && c <= 24), 32'h1);
        tally_and_finish();
    end
endmodule
`default_nettype wire
